/* File: hdl/sesr_pkg.sv */
/*
  sesr_pkg: constants and carrier types for the standard event status block.
  assumes a single 100 MHz clock domain and a decoded common-command port.
*/
package sesr_pkg;
  localparam int SESR_W = 8;
  // bit positions shared by status register and enable mask
  localparam int SESR_BIT_OPC = 0;
  localparam int SESR_BIT_QUE = 2;
  localparam int SESR_BIT_DDE = 3;
  localparam int SESR_BIT_EXE = 4;
  localparam int SESR_BIT_CME = 5;
  localparam logic [7:0] SESR_USED_MASK = 8'h3d;
  localparam logic [7:0] SESR_MASK_RESET = 8'h00;
  localparam logic [7:0] SESR_STATUS_RESET = 8'h00;
  // position of the event summary bit in the status byte
  localparam int SESR_STB_ESB = 5;
  localparam logic [7:0] SESR_STB_RESET = 8'h00;
  localparam logic [7:0] SESR_OTHER_RESET = 8'h00;
  // error class codes, the hundreds digit of an error number
  localparam logic [2:0] SESR_CLASS_CMD = 3'h1;
  localparam logic [2:0] SESR_CLASS_EXE = 3'h2;
  localparam logic [2:0] SESR_CLASS_DEV = 3'h3;
  localparam logic [2:0] SESR_CLASS_QRY = 3'h4;

  typedef enum logic [2:0] {
    SESR_CMD_NONE,
    SESR_CMD_CLEAR_STATUS,
    SESR_CMD_MASK_WRITE,
    SESR_CMD_MASK_QUERY,
    SESR_CMD_STATUS_QUERY,
    SESR_CMD_OP_COMPLETE
  } sesr_cmd_type;

  typedef struct packed {
    logic valid;
    sesr_cmd_type cmd;
    logic [7:0] data;
  } sesr_request_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } sesr_reply_type;

  typedef struct packed {
    logic valid;
    logic [2:0] err_class;
  } sesr_error_type;
endpackage : sesr_pkg

/* File: hdl/sesr_core.sv */
/*
  sesr_core: standard event status register, enable mask, status byte summary,
  operation-complete tracking and clear-status side effects.
  assumes commands arrive already decoded as one-cycle pulses on the same clock,
  and that the error queue, operation and questionable registers live outside
  and honour the clear pulses driven here.
  limitation: the summary bit and the mirrored status byte bits settle one edge
  after their cause, so readers must not sample them in the command cycle.
*/
// Summary of operation
// - the enable mask takes any value 0 to 255 on a mask write and resets to 0.
// - the event summary bit is the OR of status bits ANDed with mask bits, driven on status byte bit 5.
// - status and mask share one layout: bit 5 command, 4 execution, 3 device, 2 query, 0 op complete; 7, 6, 1 unused.
// - clear status empties the event status, operation event, questionable event and status byte registers.
// - clear status leaves every enable mask untouched.
// - clear status empties the error queue.
// - clear status returns operation-complete tracking to idle, dropping any pending request.
// - a mask query returns the stored mask with no side effect.
// - a status query returns the register and then clears it.
// - error classes 100, 200, 300 and 400 set the command, execution, device and query bits.
// - an op-complete command clears bit 0 and sets it once all pending work ends, without stalling commands.
`timescale 1ns/10ps
module sesr_core
  import sesr_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // decoded common commands
  input wire sesr_request_type i_request,
  // error reports from parser and device
  input wire sesr_error_type i_error,
  // high while any command or output change is still in progress
  input wire logic i_busy,
  // status byte bits kept elsewhere (bit 5 is replaced here)
  input wire logic [7:0] i_status_byte_other,
  // replies
  output sesr_reply_type o_reply,
  // status byte and summary
  output logic [7:0] o_status_byte,
  output logic o_event_summary,
  // clear pulses toward neighbouring registers
  output logic o_clear_error_queue,
  output logic o_clear_event_regs,
  // register views
  output logic [7:0] o_enable_mask,
  output logic o_opc_pending
);

  typedef enum logic {SESR_OPC_IDLE, SESR_OPC_WAIT} sesr_opc_state_type;

  logic [7:0] enable_mask;
  logic [7:0] standard_event_status;
  logic [7:0] status_byte_held;
  sesr_opc_state_type opc_state;
  sesr_reply_type reply;
  logic event_summary;

  // one-hot decode of an error class into event bits
  function automatic logic [7:0] sesr_class_bits(input sesr_error_type e);
    logic [7:0] b;
    b = 8'h00;
    if (e.valid) begin
      case (e.err_class)
        SESR_CLASS_CMD: b[SESR_BIT_CME] = 1'b1;
        SESR_CLASS_EXE: b[SESR_BIT_EXE] = 1'b1;
        SESR_CLASS_DEV: b[SESR_BIT_DDE] = 1'b1;
        SESR_CLASS_QRY: b[SESR_BIT_QUE] = 1'b1;
        default: b = 8'h00;
      endcase
    end
    return b;
  endfunction : sesr_class_bits

  // command decode is shared by every register, so it lives in one place
  function automatic logic sesr_is_cmd(input sesr_request_type r, input sesr_cmd_type k);
    return r.valid && (r.cmd == k);
  endfunction : sesr_is_cmd

  wire is_clear = sesr_is_cmd(i_request, SESR_CMD_CLEAR_STATUS);
  wire is_mask_write = sesr_is_cmd(i_request, SESR_CMD_MASK_WRITE);
  wire is_mask_query = sesr_is_cmd(i_request, SESR_CMD_MASK_QUERY);
  wire is_status_query = sesr_is_cmd(i_request, SESR_CMD_STATUS_QUERY);
  wire is_opc = sesr_is_cmd(i_request, SESR_CMD_OP_COMPLETE);

  // opc completes only when no work is pending; a new opc restarts the wait
  wire opc_done = (opc_state == SESR_OPC_WAIT) && !i_busy && !is_opc && !is_clear;
  logic [7:0] opc_bit;
  always_comb begin
    opc_bit = 8'h00;
    opc_bit[SESR_BIT_OPC] = opc_done;
  end
  logic [7:0] raw_set_bits;
  logic [7:0] set_bits;
  assign raw_set_bits = sesr_class_bits(i_error) | opc_bit;
  // unused positions are gated per bit so they can never latch an event
  for (genvar u = 0; u < SESR_W; u++) begin : g_used
    assign set_bits[u] = raw_set_bits[u] & SESR_USED_MASK[u];
  end

  // keep: cleared by read, clear status, or opc for bit 0
  logic [7:0] keep_bits;
  always_comb begin
    keep_bits = standard_event_status;
    if (is_status_query || is_clear) begin
      keep_bits = 8'h00;
    end
    if (is_opc) begin
      keep_bits[SESR_BIT_OPC] = 1'b0;
    end
  end
  // new events are ORed after the clear so they are never dropped
  wire [7:0] next_standard_event_status = keep_bits | set_bits;

  // the mask is gated per bit on next values, so the registered summary moves in
  // step with the status and mask it covers
  logic [7:0] next_enable_mask;
  logic [7:0] next_masked_bits;
  assign next_enable_mask = is_mask_write ? i_request.data : enable_mask;
  for (genvar g = 0; g < SESR_W; g++) begin : g_masked
    assign next_masked_bits[g] = next_standard_event_status[g] & next_enable_mask[g];
  end
  wire next_event_summary = |next_masked_bits;

  sesr_opc_state_type next_opc_state;
  always_comb begin
    case (opc_state)
      SESR_OPC_IDLE: next_opc_state = is_opc ? SESR_OPC_WAIT : SESR_OPC_IDLE;
      SESR_OPC_WAIT: next_opc_state = opc_done ? SESR_OPC_IDLE : SESR_OPC_WAIT;
      default: next_opc_state = SESR_OPC_IDLE;
    endcase
    if (is_clear) begin
      next_opc_state = SESR_OPC_IDLE;
    end
  end

  sesr_reply_type next_reply;
  always_comb begin
    next_reply.valid = is_mask_query || is_status_query;
    next_reply.data = 8'h00;
    if (is_mask_query) begin
      next_reply.data = enable_mask;
    end else if (is_status_query) begin
      next_reply.data = standard_event_status;
    end
  end

  // status byte: other bits mirrored one cycle late, cleared image held only for the cycle after clear status
  logic [7:0] next_status_byte_held;
  always_comb begin
    next_status_byte_held = i_status_byte_other;
    if (is_clear) begin
      next_status_byte_held = SESR_STB_RESET;
    end
  end

  // mask write accepts the full byte; clear status never touches it
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      enable_mask <= SESR_MASK_RESET;
    end else begin
      enable_mask <= next_enable_mask;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      standard_event_status <= SESR_STATUS_RESET;
    end else begin
      standard_event_status <= next_standard_event_status;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      status_byte_held <= SESR_STB_RESET;
    end else begin
      status_byte_held <= next_status_byte_held;
    end
  end

  // a new opc restarts the wait, clear status drops it
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      opc_state <= SESR_OPC_IDLE;
    end else begin
      opc_state <= next_opc_state;
    end
  end

  // a query answer stands for exactly one cycle
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      reply <= '0;
    end else begin
      reply <= next_reply;
    end
  end

  // registered so the summary is a clean flop output, not a gate tree
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      event_summary <= |SESR_STATUS_RESET;
    end else begin
      event_summary <= next_event_summary;
    end
  end

  always_comb begin
    o_status_byte = status_byte_held;
    o_status_byte[SESR_STB_ESB] = event_summary;
  end
  assign o_event_summary = event_summary;
  assign o_reply = reply;
  // clear pulses are combinational so neighbours act in the command cycle
  assign o_clear_error_queue = is_clear;
  assign o_clear_event_regs = is_clear;
  assign o_enable_mask = enable_mask;
  assign o_opc_pending = (opc_state == SESR_OPC_WAIT);

endmodule : sesr_core

/* File: verif/sesr_chk.sv */
/* sesr_chk: port assertions for sesr_core, bound below.
   assumes one-cycle request pulses on i_clock. */
`timescale 1ns/10ps
module sesr_chk import sesr_pkg::*; (
  input wire logic i_clock, i_resetn, i_busy, o_event_summary, o_clear_error_queue,
  o_clear_event_regs, o_opc_pending,
  input wire logic [7:0] i_status_byte_other, o_status_byte, o_enable_mask,
  input wire sesr_request_type i_request,
  input wire sesr_error_type i_error,
  input wire sesr_reply_type o_reply
);
  wire cl = i_request.valid && i_request.cmd == SESR_CMD_CLEAR_STATUS;
  wire wr = i_request.valid && i_request.cmd == SESR_CMD_MASK_WRITE;
  wire mq = i_request.valid && i_request.cmd == SESR_CMD_MASK_QUERY;
  wire sq = i_request.valid && i_request.cmd == SESR_CMD_STATUS_QUERY;
  wire oc = i_request.valid && i_request.cmd == SESR_CMD_OP_COMPLETE;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  property p_mask; wr |=> o_enable_mask == $past(i_request.data); endproperty
  a_mask: assert property (p_mask) else $error("mask write lost");
  property p_esb; o_status_byte[SESR_STB_ESB] == o_event_summary
    && (!o_event_summary || |(o_enable_mask & SESR_USED_MASK)); endproperty
  a_esb: assert property (p_esb) else $error("summary bit wrong");
  property p_unused; o_reply.valid && $past(sq) |-> !(o_reply.data & ~SESR_USED_MASK);
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit set");
  property p_clr; cl |-> o_clear_error_queue && o_clear_event_regs ##1 !o_opc_pending;
  endproperty
  a_clr: assert property (p_clr) else $error("clear effects missing");
  property p_keep; cl |=> $stable(o_enable_mask); endproperty
  a_keep: assert property (p_keep) else $error("clear touched mask");
  property p_mq; mq |=> o_reply.valid && o_reply.data == $past(o_enable_mask); endproperty
  a_mq: assert property (p_mq) else $error("mask query wrong");
  property p_rc; sq && !i_error.valid ##1 !i_error.valid [*2] ##1 sq
    |=> !(o_reply.data & 8'h3c); endproperty
  a_rc: assert property (p_rc) else $error("read did not clear");
  property p_err; i_error.valid && i_error.err_class == SESR_CLASS_CMD
    ##1 !(cl || sq) [*2] ##1 sq |=> o_reply.data[SESR_BIT_CME]; endproperty
  a_err: assert property (p_err) else $error("command error lost");
  property p_opc; o_opc_pending && !i_busy && !oc |=> !o_opc_pending; endproperty
  a_opc: assert property (p_opc) else $error("op complete stuck");
  c_clr: cover property (cl && o_opc_pending);
  c_race: cover property (sq && i_error.valid);
  c_opc: cover property (oc ##[1:8] !o_opc_pending);
endmodule : sesr_chk
bind sesr_core sesr_chk sesr_chk_inst(.*);

/* File: verif/sesr_ctl.sv */
/* sesr_ctl: controller model sending commands and errors, taking replies.
   assumes calls start after a rising edge of i_clock. */
`timescale 1ns/10ps
module sesr_ctl import sesr_pkg::*; (
  input wire logic i_clock,
  input wire sesr_reply_type i_reply,
  output sesr_request_type o_request = '0,
  output sesr_error_type o_error = '0,
  output logic o_busy = 1'b0,
  output logic [7:0] o_got = 8'h00
);
  // a reply stands one cycle, so it is taken at the edge closing it
  always @(posedge i_clock) if (i_reply.valid) o_got <= i_reply.data;
  task automatic send(input sesr_cmd_type c, input logic [7:0] d,
    input sesr_error_type e, input logic b);
    @(posedge i_clock);
    o_request <= '{c != SESR_CMD_NONE, c, d};
    o_error <= e;
    o_busy <= b;
  endtask : send
endmodule : sesr_ctl

/* File: verif/standard_event_status_reporting_test.sv */
/* standard_event_status_reporting_test: random and corner tests of sesr_core.
   assumes sesr_ctl drives requests and sesr_chk is bound. */
`timescale 1ns/10ps
`define CK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module standard_event_status_reporting_test import sesr_pkg::*;;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] i_status_byte_other = 8'h00;
  sesr_request_type i_request;
  sesr_error_type i_error, e;
  logic i_busy, o_event_summary, o_clear_error_queue, o_clear_event_regs, o_opc_pending;
  sesr_reply_type o_reply;
  logic [7:0] o_status_byte, o_enable_mask, got, d;
  logic [31:0] s = 32'h00012398;
  int err_count = 0;
  int samples_checked = 0;
  always #5 i_clock = ~i_clock;
  sesr_core sesr_core_inst(.i_clock(i_clock), .i_resetn(i_resetn), .i_request(i_request),
    .i_error(i_error), .i_busy(i_busy), .i_status_byte_other(i_status_byte_other),
    .o_reply(o_reply), .o_status_byte(o_status_byte), .o_event_summary(o_event_summary),
    .o_clear_error_queue(o_clear_error_queue), .o_clear_event_regs(o_clear_event_regs),
    .o_enable_mask(o_enable_mask), .o_opc_pending(o_opc_pending));
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  sesr_ctl sesr_ctl_inst(.i_clock, .i_reply(o_reply), .o_request(i_request),
    .o_error(i_error), .o_busy(i_busy), .o_got(got));
  function automatic logic [7:0] ev(int k);
    return (k >= 1 && k <= 4) ? 8'h40 >> k : 8'h00;
  endfunction : ev
  task automatic c(sesr_cmd_type k, logic [7:0] x = 8'h00, sesr_error_type y = '0,
    logic b = 1'b0);
    sesr_ctl_inst.send(k, x, y, b);
    i_status_byte_other <= s[7:0];
    s = lfsr(s);
  endtask : c
  task automatic rd(logic [7:0] x);
    c(SESR_CMD_STATUS_QUERY);
    c(SESR_CMD_NONE);
    c(SESR_CMD_NONE);
    #1 `CK(got, x)
  endtask : rd
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  initial begin
    repeat (10) @(posedge i_clock);
    i_resetn <= 1'b1;
    #1 `CK({o_enable_mask, o_status_byte}, 16'h0000)
    for (int i = 0; i < 10; i++) begin
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : s[15:8];
      c(SESR_CMD_MASK_WRITE, d);
      c(SESR_CMD_MASK_QUERY);
      c(SESR_CMD_NONE);
      c(SESR_CMD_NONE);
      #1 `CK(got, d)
      `CK(o_enable_mask, d)
      rd(8'h00);
    end
    $display("mask test done");
    c(SESR_CMD_MASK_WRITE, 8'hff);
    for (int k = 0; k < 8; k++) begin
      e = '{1'b1, 3'(k)};
      c(SESR_CMD_STATUS_QUERY, 8'h00, e);
      c(SESR_CMD_NONE);
      c(SESR_CMD_NONE);
      #1 `CK(o_event_summary, ev(k) != 8'h00)
      rd(ev(k));
    end
    $display("error test done");
    c(SESR_CMD_NONE, 8'h00, '{1'b1, SESR_CLASS_EXE});
    c(SESR_CMD_OP_COMPLETE, 8'h00, '0, 1'b1);
    c(SESR_CMD_CLEAR_STATUS, 8'h00, '0, 1'b1);
    #1 `CK({o_clear_error_queue, o_clear_event_regs}, 2'h3)
    c(SESR_CMD_NONE, 8'h00, '0, 1'b1);
    #1 `CK(o_status_byte, SESR_STB_RESET)
    c(SESR_CMD_NONE, 8'h00, '0, 1'b1);
    #1 `CK({o_opc_pending, o_event_summary, o_enable_mask}, 10'h0ff)
    rd(8'h00);
    $display("clear test done");
    c(SESR_CMD_OP_COMPLETE, 8'h00, '0, 1'b1);
    repeat (4) c(SESR_CMD_MASK_QUERY, 8'h00, '0, 1'b1);
    #1 `CK({o_opc_pending, got}, 9'h1ff)
    for (int w = 0; o_opc_pending && w < 10; w++) begin
      c(SESR_CMD_NONE);
      #1;
    end
    if (o_opc_pending) begin
      err_count++;
      $display("MISMATCH t=%0t op complete never reported", $time);
    end else begin
      rd(8'h01);
    end
    $display("opc test done");
    end_sim();
  end
endmodule : standard_event_status_reporting_test
